// [pkg/dtc_pkg.sv]
// Purpose: Shared constants for the dual timer/counter block
// Assumes: Byte-wide special function register bus
// Notes:   Offsets are byte addresses on that bus
`default_nettype none

package dtc_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_TCTL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_REGISTER = 8'h89;
	localparam logic [7:0] ADDR_TL0  = 8'h8A;
	localparam logic [7:0] ADDR_TL1  = 8'h8B;
	localparam logic [7:0] ADDR_TH0  = 8'h8C;
	localparam logic [7:0] ADDR_TH1  = 8'h8D;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] TCTL_RESET  = 8'h00;
	localparam logic [7:0] TIMER_MODE_REGISTER_RESET  = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE  = 8'h00;

	// ----------------------------------------
	// Control register bit positions
	// ----------------------------------------
	localparam int TCTL_TF1 = 7;
	localparam int TCTL_TR1 = 6;
	localparam int TCTL_TF0 = 5;
	localparam int TCTL_TR0 = 4;
	localparam int TCTL_IE1 = 3;
	localparam int TCTL_IT1 = 2;
	localparam int TCTL_IE0 = 1;
	localparam int TCTL_IT0 = 0;

	// ----------------------------------------
	// Mode register nibbles and fields
	// ----------------------------------------
	localparam int TIMER_MODE_REGISTER_T1   = 4;
	localparam int TIMER_MODE_REGISTER_T0   = 0;
	localparam int FLD_GATE  = 3;
	localparam int FLD_CT    = 2;
	localparam int FLD_MODE  = 0;
	localparam int MODE_W    = 2;

	// ----------------------------------------
	// Pin positions and timing
	// ----------------------------------------
	localparam int PIN_EXT_IRQ0_PIN  = 0;
	localparam int PIN_EXT_IRQ1_PIN  = 1;
	localparam int PIN_CNT0  = 2;
	localparam int PIN_CNT1  = 3;
	localparam int PIN_COUNT = 4;
	localparam int PRESC_BITS = 5;
	localparam logic [3:0] MC_LAST = 4'hB;
	localparam logic [3:0] MC_ZERO = 4'h0;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'b00,
		DTC_MODE_16BIT  = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT  = 2'b11
	} dtc_mode_e;

endpackage

`default_nettype wire

// [src/dtc_pin_sync.sv]
// Purpose: Two-flop synchroniser with falling-edge detect per pin
// Assumes: Pins are asynchronous to ref_clk
// Notes:   Edge detect reads only the second stage and beyond
`default_nettype none

module dtc_pin_sync #(
	parameter int WIDTH = dtc_pkg::PIN_COUNT
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_lvl,
	output logic      [WIDTH-1:0] pin_fall
);
	logic [WIDTH-1:0] meta_q, meta_d;
	logic [WIDTH-1:0] sync_q, sync_d;
	logic [WIDTH-1:0] prev_q, prev_d;

	// Idle high so a pin held low at reset release counts once
	always_comb begin
		meta_d = pin_async;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign pin_lvl  = sync_q;
	assign pin_fall = prev_q & ~sync_q;

endmodule // dtc_pin_sync

`default_nettype wire

// [src/dtc_count_unit.sv]
// Purpose: One timer built from a low and a high count byte
// Assumes: count_en is a single-cycle pulse per counted event
// Notes:   Software writes win over the increment in the same cycle
`default_nettype none

module dtc_count_unit
	import dtc_pkg::*;
#(
	parameter int PRESC_W = dtc_pkg::PRESC_BITS
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire dtc_pkg::dtc_mode_e mode,
	input  wire logic             count_en,
	input  wire logic             wr_low,
	input  wire logic             wr_high,
	input  wire logic [7:0]       wdata,
	output logic      [7:0]       count_low,
	output logic      [7:0]       count_high,
	output logic                  overflow
);
	logic [7:0] low_q, low_d;
	logic [7:0] high_q, high_d;

	always_comb begin
		low_d    = low_q;
		high_d   = high_q;
		overflow = 1'b0;
		if (count_en) begin
			unique case (mode)
				DTC_MODE_13BIT: begin
					// Upper low-byte bits are left alone; software ignores them
					low_d[PRESC_W-1:0] = low_q[PRESC_W-1:0] + 1'b1;
					if (&low_q[PRESC_W-1:0]) begin
						high_d   = high_q + 8'h01;
						overflow = &high_q;
					end
				end
				DTC_MODE_16BIT: begin
					{high_d, low_d} = {high_q, low_q} + 16'h0001;
					overflow = &{high_q, low_q};
				end
				// Reload and split modes are not built here: the count holds
				DTC_MODE_RELOAD, DTC_MODE_SPLIT: begin
					overflow = 1'b0;
				end
			endcase
		end
		if (wr_low) begin
			low_d = wdata;
		end
		if (wr_high) begin
			high_d = wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			low_q  <= COUNT_RESET;
			high_q <= COUNT_RESET;
		end else begin
			low_q  <= low_d;
			high_q <= high_d;
		end
	end

	assign count_low  = low_q;
	assign count_high = high_q;

endmodule // dtc_count_unit

`default_nettype wire

// [src/dtc_top.sv]
// Purpose: Two timer/counters with external interrupt request flags
// Assumes: Byte-wide register bus, vector acknowledge pulses from core
// Notes:   Modes 2 and 3 hold the count; only modes 0 and 1 count
`default_nettype none

// Notes on behaviour
// - Timer1 overflow sets bit 7; vector clears
// - Timer0 overflow sets bit 5; vector clears
// - Bit 6 runs or stops timer1
// - Bit 4 runs or stops timer0
// - Bit 3 ext irq1 flag, edge or level
// - Bit 1 ext irq0 flag, edge or level
// - Bit 2 picks ext irq1 edge/level
// - Bit 0 picks ext irq0 edge/level
// - Each timer is two byte registers
// - Mode 0 uses divide-by-32 prescaler
// - Mode 0: high byte plus low five
// - Wrap to zero sets overflow flag
// - Count only if run and gate passes
// - Setting run leaves count untouched
// - Mode 1 is full sixteen-bit count
// - Both timers behave identically
// - Two-bit mode field per timer
// - Counter/timer select picks source
// - Gate bit ties run to pin high
module dtc_top (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       vec_ack_ext0,
	input  wire logic       vec_ack_tmr0,
	input  wire logic       vec_ack_ext1,
	input  wire logic       vec_ack_tmr1,
	input  wire logic       ext_irq0_pin,
	input  wire logic       ext_irq1_pin,
	input  wire logic       timer0_count_pin,
	input  wire logic       timer1_count_pin,
	output logic            irq_req_ext0,
	output logic            irq_req_tmr0,
	output logic            irq_req_ext1,
	output logic            irq_req_tmr1
);
	import dtc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction

	function automatic logic run_gate(input logic run, input logic gate, input logic pin);
		return run & (~gate | pin);
	endfunction

	function automatic logic count_pulse(input logic ct, input logic tick, input logic fall);
		return ct ? fall : tick;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]           tctl_q, tctl_d;
	logic [7:0]           timer_mode_register_q, timer_mode_register_d;
	logic [3:0]           mc_cnt_q, mc_cnt_d;
	logic [7:0]           rdata_q, rdata_d;
	logic [PIN_COUNT-1:0] pin_lvl;
	logic [PIN_COUNT-1:0] pin_fall;
	logic                 mc_tick;
	logic                 en0, en1;
	logic                 ovf0, ovf1;
	logic                 wr_tl0, wr_th0, wr_tl1, wr_th1;
	logic [7:0]           tl0, th0, tl1, th1;
	dtc_mode_e            mode0, mode1;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	dtc_pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.pin_async({timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin}),
		.pin_lvl  (pin_lvl),
		.pin_fall (pin_fall)
	);

	// ----------------------------------------
	// Machine cycle divider
	// ----------------------------------------
	assign mc_tick = (mc_cnt_q == MC_LAST);

	always_comb begin
		mc_cnt_d = mc_tick ? MC_ZERO : mc_cnt_q + 4'h1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mc_cnt_q <= MC_ZERO;
		end else begin
			mc_cnt_q <= mc_cnt_d;
		end
	end

	// ----------------------------------------
	// Count enables, same logic for both timers
	// ----------------------------------------
	assign mode0 = dtc_mode_e'(timer_mode_register_q[TIMER_MODE_REGISTER_T0+FLD_MODE +: MODE_W]);
	assign mode1 = dtc_mode_e'(timer_mode_register_q[TIMER_MODE_REGISTER_T1+FLD_MODE +: MODE_W]);

	// Gate on INT pin high, so low pulse widths need the pin inverted off-chip
	assign en0 = run_gate(tctl_q[TCTL_TR0], timer_mode_register_q[TIMER_MODE_REGISTER_T0+FLD_GATE], pin_lvl[PIN_EXT_IRQ0_PIN])
		& count_pulse(timer_mode_register_q[TIMER_MODE_REGISTER_T0+FLD_CT], mc_tick, pin_fall[PIN_CNT0]);
	assign en1 = run_gate(tctl_q[TCTL_TR1], timer_mode_register_q[TIMER_MODE_REGISTER_T1+FLD_GATE], pin_lvl[PIN_EXT_IRQ1_PIN])
		& count_pulse(timer_mode_register_q[TIMER_MODE_REGISTER_T1+FLD_CT], mc_tick, pin_fall[PIN_CNT1]);

	assign wr_tl0 = sfr_wr & reg_hit(sfr_addr, ADDR_TL0);
	assign wr_th0 = sfr_wr & reg_hit(sfr_addr, ADDR_TH0);
	assign wr_tl1 = sfr_wr & reg_hit(sfr_addr, ADDR_TL1);
	assign wr_th1 = sfr_wr & reg_hit(sfr_addr, ADDR_TH1);

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	dtc_count_unit #(
		.PRESC_W(PRESC_BITS)
	) u_tmr0 (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.mode      (mode0),
		.count_en  (en0),
		.wr_low    (wr_tl0),
		.wr_high   (wr_th0),
		.wdata     (sfr_wdata),
		.count_low (tl0),
		.count_high(th0),
		.overflow  (ovf0)
	);

	dtc_count_unit #(
		.PRESC_W(PRESC_BITS)
	) u_tmr1 (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.mode      (mode1),
		.count_en  (en1),
		.wr_low    (wr_tl1),
		.wr_high   (wr_th1),
		.wdata     (sfr_wdata),
		.count_low (tl1),
		.count_high(th1),
		.overflow  (ovf1)
	);

	// ----------------------------------------
	// Control and mode registers
	// ----------------------------------------
	always_comb begin
		tctl_d = tctl_q;
		timer_mode_register_d = timer_mode_register_q;
		// Run bits only gate the count, never touch it
		if (sfr_wr && reg_hit(sfr_addr, ADDR_TCTL)) begin
			tctl_d = sfr_wdata;
		end
		if (sfr_wr && reg_hit(sfr_addr, ADDR_TIMER_MODE_REGISTER)) begin
			timer_mode_register_d = sfr_wdata;
		end
		// Clears first, then sets, so a same-cycle event is never lost
		if (vec_ack_tmr1) begin
			tctl_d[TCTL_TF1] = 1'b0;
		end
		if (ovf1) begin
			tctl_d[TCTL_TF1] = 1'b1;
		end
		if (vec_ack_tmr0) begin
			tctl_d[TCTL_TF0] = 1'b0;
		end
		if (ovf0) begin
			tctl_d[TCTL_TF0] = 1'b1;
		end
		if (tctl_q[TCTL_IT1]) begin
			if (vec_ack_ext1) begin
				tctl_d[TCTL_IE1] = 1'b0;
			end
			if (pin_fall[PIN_EXT_IRQ1_PIN]) begin
				tctl_d[TCTL_IE1] = 1'b1;
			end
		end else begin
			tctl_d[TCTL_IE1] = ~pin_lvl[PIN_EXT_IRQ1_PIN];
		end
		if (tctl_q[TCTL_IT0]) begin
			if (vec_ack_ext0) begin
				tctl_d[TCTL_IE0] = 1'b0;
			end
			if (pin_fall[PIN_EXT_IRQ0_PIN]) begin
				tctl_d[TCTL_IE0] = 1'b1;
			end
		end else begin
			tctl_d[TCTL_IE0] = ~pin_lvl[PIN_EXT_IRQ0_PIN];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tctl_q <= TCTL_RESET;
			timer_mode_register_q <= TIMER_MODE_REGISTER_RESET;
		end else begin
			tctl_q <= tctl_d;
			timer_mode_register_q <= timer_mode_register_d;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rdata_d = RDATA_IDLE;
		if (sfr_rd) begin
			case (sfr_addr)
				ADDR_TCTL: rdata_d = tctl_q;
				ADDR_TIMER_MODE_REGISTER: rdata_d = timer_mode_register_q;
				ADDR_TL0:  rdata_d = tl0;
				ADDR_TL1:  rdata_d = tl1;
				ADDR_TH0:  rdata_d = th0;
				ADDR_TH1:  rdata_d = th1;
				default:   rdata_d = RDATA_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata_q <= RDATA_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata    = rdata_q;
	assign irq_req_tmr1 = tctl_q[TCTL_TF1];
	assign irq_req_tmr0 = tctl_q[TCTL_TF0];
	assign irq_req_ext1 = tctl_q[TCTL_IE1];
	assign irq_req_ext0 = tctl_q[TCTL_IE0];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_quiet_gap;
		(!mc_tick)[*8] ##1 (!mc_tick)[*3];
	endsequence

	property p_tf1_set;
		ovf1 |=> irq_req_tmr1;
	endproperty
	a_tf1_set: assert property (p_tf1_set) else $error("timer1 overflow flag not set");

	property p_tf1_clr;
		vec_ack_tmr1 && !ovf1 && !sfr_wr |=> !irq_req_tmr1;
	endproperty
	a_tf1_clr: assert property (p_tf1_clr) else $error("timer1 flag not cleared");

	property p_tf0_set;
		ovf0 && !wr_tl0 |=> irq_req_tmr0 && tl0[PRESC_BITS-1:0] == 5'h00;
	endproperty
	a_tf0_set: assert property (p_tf0_set) else $error("timer0 overflow flag wrong");

	property p_run0_hold;
		!tctl_q[TCTL_TR0] && !wr_tl0 && !wr_th0 |=> $stable(tl0) && $stable(th0);
	endproperty
	a_run0_hold: assert property (p_run0_hold) else $error("timer0 moved while off");

	property p_run1_hold;
		!tctl_q[TCTL_TR1] && !wr_tl1 && !wr_th1 |=> $stable(tl1) && $stable(th1);
	endproperty
	a_run1_hold: assert property (p_run1_hold) else $error("timer1 moved while off");

	property p_ie1_edge;
		tctl_q[TCTL_IT1] && pin_fall[PIN_EXT_IRQ1_PIN] |=> irq_req_ext1;
	endproperty
	a_ie1_edge: assert property (p_ie1_edge) else $error("ext irq1 edge missed");

	property p_ie0_level;
		!tctl_q[TCTL_IT0] && !tctl_d[TCTL_IT0] |=> irq_req_ext0 == !$past(pin_lvl[PIN_EXT_IRQ0_PIN]);
	endproperty
	a_ie0_level: assert property (p_ie0_level) else $error("ext irq0 level wrong");

	property p_gate0;
		timer_mode_register_q[TIMER_MODE_REGISTER_T0+FLD_GATE] && !pin_lvl[PIN_EXT_IRQ0_PIN] |-> !en0;
	endproperty
	a_gate0: assert property (p_gate0) else $error("timer0 ran with gate low");

	property p_mc_period;
		mc_tick |=> s_quiet_gap ##1 mc_tick;
	endproperty
	a_mc_period: assert property (p_mc_period) else $error("machine cycle not twelve");

	property p_mode0_carry;
		en0 && mode0 == DTC_MODE_13BIT && &tl0[PRESC_BITS-1:0] && !wr_th0
			|=> th0 == $past(th0) + 8'h01;
	endproperty
	a_mode0_carry: assert property (p_mode0_carry) else $error("mode 0 carry wrong");

	property p_mode1_carry;
		en1 && mode1 == DTC_MODE_16BIT && tl1 == 8'hFF && !wr_th1 && !wr_tl1
			|=> th1 == $past(th1) + 8'h01 && tl1 == 8'h00;
	endproperty
	a_mode1_carry: assert property (p_mode1_carry) else $error("mode 1 carry wrong");

endmodule // dtc_top

`default_nettype wire

// [testbench/dtc_core_model.sv]
// Purpose: Core-side vectoring model that acknowledges pending requests
// Assumes: Requests are levels; acknowledge is a one-cycle pulse
// Notes:   Holds off four cycles after each vector, like an ISR entry
`default_nettype none

module dtc_core_model (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic ack_en,
	input  wire logic irq_req_ext0,
	input  wire logic irq_req_tmr0,
	input  wire logic irq_req_ext1,
	input  wire logic irq_req_tmr1,
	output logic      vec_ack_ext0,
	output logic      vec_ack_tmr0,
	output logic      vec_ack_ext1,
	output logic      vec_ack_tmr1
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] req;
	logic [3:0] ack_q;
	logic [2:0] hold_q;

	// ----------------------------------------
	// Priority vectoring, ext0 first
	// ----------------------------------------
	assign req = {irq_req_tmr1, irq_req_ext1, irq_req_tmr0, irq_req_ext0};
	assign {vec_ack_tmr1, vec_ack_ext1, vec_ack_tmr0, vec_ack_ext0} = ack_q;

	// Hold-off stops a second ack before the flag has dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_q  <= 4'h0;
			hold_q <= 3'h0;
		end else begin
			ack_q <= 4'h0;
			if (hold_q != 3'h0) begin
				hold_q <= hold_q - 3'h1;
			end else if (ack_en && req != 4'h0) begin
				ack_q  <= req & (~req + 4'h1);
				hold_q <= 3'h4;
			end
		end
	end
endmodule // dtc_core_model

`default_nettype wire

// [testbench/dtc_top_tb.sv]
// Purpose: Self-checking bench for the dual timer/counter block
// Assumes: Register bus strobes are one-cycle pulses
// Notes:   Mode 0 low-byte upper bits are masked, the count unit leaves them alone
`default_nettype none

module dtc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dtc_pkg::*;

	logic       ref_clk, rst_n, sfr_wr, sfr_rd, ack_en;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
	logic [1:0] ext_pin, cnt_pin;
	logic       irq_req_ext0, irq_req_tmr0, irq_req_ext1, irq_req_tmr1;
	logic       vec_ack_ext0, vec_ack_tmr0, vec_ack_ext1, vec_ack_tmr1;
	logic [1:0] ext_req, tmr_req;
	int         error_cnt, n_checks, k;

	assign ext_req = {irq_req_ext1, irq_req_ext0};
	assign tmr_req = {irq_req_tmr1, irq_req_tmr0};

	dtc_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.vec_ack_ext0(vec_ack_ext0), .vec_ack_tmr0(vec_ack_tmr0),
		.vec_ack_ext1(vec_ack_ext1), .vec_ack_tmr1(vec_ack_tmr1),
		.ext_irq0_pin(ext_pin[0]), .ext_irq1_pin(ext_pin[1]),
		.timer0_count_pin(cnt_pin[0]), .timer1_count_pin(cnt_pin[1]),
		.irq_req_ext0(irq_req_ext0), .irq_req_tmr0(irq_req_tmr0),
		.irq_req_ext1(irq_req_ext1), .irq_req_tmr1(irq_req_tmr1));

	dtc_core_model core (.ref_clk(ref_clk), .rst_n(rst_n), .ack_en(ack_en),
		.irq_req_ext0(irq_req_ext0), .irq_req_tmr0(irq_req_tmr0),
		.irq_req_ext1(irq_req_ext1), .irq_req_tmr1(irq_req_tmr1),
		.vec_ack_ext0(vec_ack_ext0), .vec_ack_tmr0(vec_ack_tmr0),
		.vec_ack_ext1(vec_ack_ext1), .vec_ack_tmr1(vec_ack_tmr1));

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1 d = sfr_rdata;
	endtask

	task automatic ack_pulse();
		@(posedge ref_clk);
		ack_en <= 1'b1;
		repeat (8) @(posedge ref_clk);
		ack_en <= 1'b0;
		#1;
	endtask

	task automatic pulse_cnt(input int t, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			cnt_pin[t] <= 1'b0;
			repeat (4) @(posedge ref_clk);
			cnt_pin[t] <= 1'b1;
			repeat (4) @(posedge ref_clk);
		end
	endtask

	// One machine tick from a preset count, then stop and inspect
	task automatic tick_case(input int t, input logic [3:0] nib, input logic [7:0] th,
		input logic [7:0] tl, input logic [7:0] eth, input logic [7:0] etl,
		input logic [7:0] mask, input logic ovf);
		logic [7:0] lo_a, hi_a, run_b, flg_b;
		logic       irq;
		lo_a = t ? ADDR_TL1 : ADDR_TL0;
		hi_a = t ? ADDR_TH1 : ADDR_TH0;
		run_b = t ? 8'h40 : 8'h10;
		flg_b = t ? 8'h80 : 8'h20;
		wr(ADDR_TCTL, 8'h00);
		wr(ADDR_TIMER_MODE_REGISTER, t ? {nib, 4'h0} : {4'h0, nib});
		wr(hi_a, th);
		wr(lo_a, tl);
		wr(ADDR_TCTL, run_b);
		v = tl;
		for (k = 0; k < 10 && v === tl; k++) rd(lo_a, v);
		irq = tmr_req[t];
		wr(ADDR_TCTL, ovf ? flg_b : 8'h00);
		check({7'h0, irq}, {7'h0, ovf});
		rd(lo_a, v);
		check(v & mask, etl & mask);
		rd(hi_a, v);
		check(v, eth);
		if (ovf) begin
			rd(ADDR_TCTL, v);
			check(v, flg_b);
			ack_pulse();
			check({7'h0, tmr_req[t]}, 8'h00);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Clock, reset and watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Whole sequence needs about 450 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		conclude();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		ack_en = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		ext_pin = 2'b11;
		cnt_pin = 2'b11;
		error_cnt = 0;
		n_checks = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 7; a++) begin
			rd((a < 6) ? (ADDR_TCTL + 8'(a)) : 8'h90, v);
			check(v, 8'h00);
		end
		$display("reset values done");

		tick_case(0, 4'h1, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 1'b1);
		tick_case(1, 4'h0, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h1F, 1'b1);
		tick_case(1, 4'h1, 8'hFF, 8'h1F, 8'hFF, 8'h20, 8'hFF, 1'b0);
		tick_case(0, 4'h0, 8'h00, 8'hFF, 8'h01, 8'hE0, 8'h1F, 1'b0);
		// Unbuilt modes must hold the count and never flag
		tick_case(0, 4'h2, 8'h12, 8'h34, 8'h12, 8'h34, 8'hFF, 1'b0);
		tick_case(1, 4'h3, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 1'b0);
		$display("mode tick tests done");

		wr(ADDR_TIMER_MODE_REGISTER, 8'h09);
		wr(ADDR_TL0, 8'h00);
		wr(ADDR_TH0, 8'h00);
		ext_pin[0] <= 1'b0;
		wr(ADDR_TCTL, 8'h10);
		repeat (30) @(posedge ref_clk);
		rd(ADDR_TL0, v);
		check(v, 8'h00);
		check({7'h0, ext_req[0]}, 8'h01);
		ack_pulse();
		check({7'h0, ext_req[0]}, 8'h01);
		@(posedge ref_clk);
		ext_pin[0] <= 1'b1;
		repeat (30) @(posedge ref_clk);
		rd(ADDR_TL0, v);
		check({7'h0, v != 8'h00}, 8'h01);
		check({7'h0, ext_req[0]}, 8'h00);
		wr(ADDR_TCTL, 8'h00);
		$display("gate and level test done");

		wr(ADDR_TIMER_MODE_REGISTER, 8'h50);
		wr(ADDR_TL1, 8'h00);
		wr(ADDR_TH1, 8'h00);
		wr(ADDR_TCTL, 8'h40);
		pulse_cnt(1, 3);
		rd(ADDR_TL1, v);
		check(v, 8'h03);
		// Read data stands one cycle only
		@(posedge ref_clk);
		#1 check(sfr_rdata, 8'h00);
		wr(ADDR_TCTL, 8'h00);
		pulse_cnt(1, 2);
		rd(ADDR_TL1, v);
		check(v, 8'h03);
		wr(ADDR_TIMER_MODE_REGISTER, 8'h05);
		wr(ADDR_TL0, 8'h00);
		wr(ADDR_TH0, 8'h00);
		wr(ADDR_TCTL, 8'h10);
		pulse_cnt(0, 2);
		rd(ADDR_TL0, v);
		check(v, 8'h02);
		wr(ADDR_TCTL, 8'h00);
		$display("counter test done");

		for (int i = 0; i < 2; i++) begin
			wr(ADDR_TCTL, 8'h05);
			@(posedge ref_clk);
			ext_pin[i] <= 1'b0;
			repeat (6) @(posedge ref_clk);
			ext_pin[i] <= 1'b1;
			repeat (4) @(posedge ref_clk);
			rd(ADDR_TCTL, v);
			check(v, i ? 8'h0D : 8'h07);
			ack_pulse();
			check({7'h0, ext_req[i]}, 8'h00);
		end
		$display("edge trigger test done");
		conclude();
	end
endmodule // dtc_top_tb

`default_nettype wire
